/* File: design/wvr_pkg.sv */
// Constants and carrier types for the waveform readout register block
// Behaviour
// - Edge validity sits in bits 14:13; 00 none, 01 edge zero only, 10 both.
// - Edge position word carries edge zero high byte, edge one low byte, unsigned.
// - With one valid edge the edge-one byte is undefined; host ignores it.
// - Reading type select returns latch flag in bit 9 and type in low byte.
// - Latch flag clears at start-up, on mode change and on measured value reset, unless a select read captures in that same cycle.
// - Each window address returns four one-byte samples; window spans 402763 to 402889.
// - For reference waveform, range register gives end point high, start point low.
// - Reading type select captures current waveform; later reads return that snapshot.
package wvr_pkg;

  // Holding register numbers as the host addresses them
  localparam logic [19:0] REG_TYPE_SEL  = 20'h62549;
  localparam logic [19:0] REG_WIN_FIRST = 20'h6254B;
  localparam logic [19:0] REG_WIN_LAST  = 20'h625C9;
  localparam logic [19:0] REG_RANGE     = 20'h625CB;
  localparam logic [19:0] REG_EDGE_POS  = 20'h625CF;

  // Field positions and codes
  localparam int          SEL_FLAG_BIT = 9;
  localparam int          EDGE_VLD_LSB = 13;
  localparam logic [7:0]  TYPE_REF     = 8'h00;
  localparam logic [1:0]  EDGE_NONE    = 2'h0;
  localparam logic [1:0]  EDGE_ONE     = 2'h1;
  localparam logic [1:0]  EDGE_BOTH    = 2'h2;

  // Reset values and the bank index sum
  localparam logic [7:0]  TYPE_RST     = 8'h00;
  localparam logic [1:0]  WR_BANK_RST  = 2'h0;
  localparam logic [1:0]  RDY_BANK_RST = 2'h1;
  localparam logic [1:0]  SNP_BANK_RST = 2'h2;
  localparam logic [1:0]  BANK_SUM     = 2'h3;

  // Memory geometry: four banks of 128 words, three in use
  localparam int          WIN_WORDS = 127;
  localparam int          MEM_AW    = 9;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [19:0] addr;
    logic [15:0] wdata;
  } wvr_req_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [31:0] data;
  } wvr_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [6:0]  idx;
    logic [31:0] data;
  } wvr_smp_t;

  typedef struct packed {
    logic [1:0]  edge_vld;
    logic [7:0]  pos0;
    logic [7:0]  pos1;
    logic [7:0]  rng_end;
    logic [7:0]  rng_start;
  } wvr_info_t;

  typedef enum logic [5:0] {
    K_NONE = 6'b000001,
    K_SEL  = 6'b000010,
    K_WIN  = 6'b000100,
    K_RNG  = 6'b001000,
    K_EDG  = 6'b010000,
    K_ERR  = 6'b100000
  } wvr_kind_t;

endpackage

/* File: design/wvr_wave_mem.sv */
// Banked sample memory with registered read data
`timescale 1ns/1ns
module wvr_wave_mem (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_we,
  input  wire logic [wvr_pkg::MEM_AW-1:0] i_waddr,
  input  wire logic [31:0]               i_wdata,
  input  wire logic [wvr_pkg::MEM_AW-1:0] i_raddr,
  output logic      [31:0]               o_rdata
);
  import wvr_pkg::*;

  logic [31:0] mem_q [0:(1<<MEM_AW)-1];
  logic [31:0] rdata_d;

  // Storage has no reset so it maps onto block RAM
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_comb begin
    rdata_d = mem_q[i_raddr];
  end

  // Read data leaves through a register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h00000000;
    end else begin
      o_rdata <= rdata_d;
    end
  end
endmodule

/* File: design/wvr_top.sv */
// Waveform latch and holding register readout
`timescale 1ns/1ns
module wvr_top (
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  input  wire wvr_pkg::wvr_req_t  i_req,
  output wvr_pkg::wvr_rsp_t       o_rsp,
  input  wire wvr_pkg::wvr_smp_t  i_smp,
  input  wire logic              i_frame_done,
  input  wire wvr_pkg::wvr_info_t i_frame_info,
  input  wire logic              i_mode_change,
  input  wire logic              i_meas_reset
);
  import wvr_pkg::*;

  // Bank ownership and latch state
  logic [1:0] wr_bank_q, wr_bank_d;
  logic [1:0] rdy_bank_q, rdy_bank_d;
  logic [1:0] snp_bank_q, snp_bank_d;
  logic       have_rdy_q, have_rdy_d;
  logic       flag_q, flag_d;
  wvr_info_t  rdy_info_q, rdy_info_d;
  wvr_info_t  snp_info_q, snp_info_d;
  logic [7:0] type_q, type_d;

  // Request pipeline
  wvr_kind_t  kind1_q, kind1_d;
  wvr_kind_t  kind2_q, kind2_d;
  wvr_rsp_t   rsp_d;

  logic       hit_sel, hit_win, hit_rng, hit_edg;
  logic       capture, clear_ev;
  logic [6:0] win_idx;
  logic [31:0] mem_rdata;
  logic        mem_we;

  // Address decode on the arriving request
  always_comb begin
    hit_sel  = i_req.valid && (i_req.addr == REG_TYPE_SEL);
    hit_win  = i_req.valid && (i_req.addr >= REG_WIN_FIRST) && (i_req.addr <= REG_WIN_LAST);
    hit_rng  = i_req.valid && (i_req.addr == REG_RANGE);
    hit_edg  = i_req.valid && (i_req.addr == REG_EDGE_POS);
    win_idx  = 7'(i_req.addr - REG_WIN_FIRST);
    capture  = hit_sel && !i_req.write;
    clear_ev = i_mode_change || i_meas_reset;
    mem_we   = i_smp.valid && (i_smp.idx < 7'(WIN_WORDS));
  end

  // Three banks rotate so the writer never touches the ready or snapshot bank
  always_comb begin
    snp_bank_d = snp_bank_q;
    snp_info_d = snp_info_q;
    rdy_bank_d = rdy_bank_q;
    rdy_info_d = rdy_info_q;
    wr_bank_d  = wr_bank_q;
    have_rdy_d = have_rdy_q;
    flag_d     = flag_q;
    type_d     = type_q;
    if (hit_sel && i_req.write) begin
      type_d = i_req.wdata[7:0];
    end
    if (clear_ev) begin
      flag_d     = 1'b0;
      have_rdy_d = 1'b0;
    end
    if (capture && have_rdy_q) begin
      snp_bank_d = rdy_bank_q;
      snp_info_d = rdy_info_q;
      flag_d     = 1'b1;
    end
    if (i_frame_done) begin
      rdy_bank_d = wr_bank_q;
      rdy_info_d = i_frame_info;
      have_rdy_d = 1'b1;
      wr_bank_d  = 2'(BANK_SUM - wr_bank_q - snp_bank_d);
    end
  end

  // Latch state registers; flag and ready cleared at start-up
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_bank_q  <= WR_BANK_RST;
      rdy_bank_q <= RDY_BANK_RST;
      snp_bank_q <= SNP_BANK_RST;
      have_rdy_q <= 1'b0;
      flag_q     <= 1'b0;
      rdy_info_q <= '0;
      snp_info_q <= '0;
      type_q     <= TYPE_RST;
    end else begin
      wr_bank_q  <= wr_bank_d;
      rdy_bank_q <= rdy_bank_d;
      snp_bank_q <= snp_bank_d;
      have_rdy_q <= have_rdy_d;
      flag_q     <= flag_d;
      rdy_info_q <= rdy_info_d;
      snp_info_q <= snp_info_d;
      type_q     <= type_d;
    end
  end

  // Window reads come from the snapshot bank selected at the request edge
  wvr_wave_mem u_mem (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_we       (mem_we),
    .i_waddr    ({wr_bank_q, i_smp.idx}),
    .i_wdata    (i_smp.data),
    .i_raddr    ({snp_bank_q, win_idx}),
    .o_rdata    (mem_rdata)
  );

  // Classify the request; writes are only legal on the type select
  always_comb begin
    kind1_d = K_NONE;
    if (i_req.valid) begin
      kind1_d = K_ERR;
      if (hit_sel) begin
        kind1_d = K_SEL;
      end else if (!i_req.write && hit_win) begin
        kind1_d = K_WIN;
      end else if (!i_req.write && hit_rng) begin
        kind1_d = K_RNG;
      end else if (!i_req.write && hit_edg) begin
        kind1_d = K_EDG;
      end
    end
    kind2_d = kind1_q;
  end

  // Answer word built one cycle after capture so the flag shows the new state
  always_comb begin
    rsp_d       = '0;
    rsp_d.valid = (kind1_q != K_NONE);
    unique case (kind1_q)
      K_NONE: rsp_d.data = 32'h00000000;
      K_SEL: begin
        rsp_d.data[SEL_FLAG_BIT] = flag_q;
        rsp_d.data[7:0]          = type_q;
      end
      K_WIN: rsp_d.data = mem_rdata;
      K_RNG: begin
        if (type_q == TYPE_REF) begin
          rsp_d.data[15:8] = snp_info_q.rng_end;
          rsp_d.data[7:0]  = snp_info_q.rng_start;
        end else begin
          rsp_d.data[EDGE_VLD_LSB+:2] = snp_info_q.edge_vld;
        end
      end
      K_EDG: begin
        rsp_d.data[15:8] = snp_info_q.pos0;
        // Undefined edge-one byte is forced to zero rather than leaked
        rsp_d.data[7:0]  = (snp_info_q.edge_vld == EDGE_BOTH) ? snp_info_q.pos1 : 8'h00;
      end
      K_ERR: rsp_d.err = 1'b1;
      default: rsp_d.err = 1'b1;
    endcase
  end

  // Pipeline and answer registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      kind1_q <= K_NONE;
      kind2_q <= K_NONE;
      o_rsp   <= '0;
    end else begin
      kind1_q <= kind1_d;
      kind2_q <= kind2_d;
      o_rsp   <= rsp_d;
    end
  end

  // Checks
  property p_flag_clear;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      clear_ev && !(capture && have_rdy_q) |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_capture;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      capture && have_rdy_q |=> flag_q && (snp_bank_q == $past(rdy_bank_q));
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_sel_flag;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      kind1_q == K_SEL |=> o_rsp.valid && (o_rsp.data[SEL_FLAG_BIT] == $past(flag_q))
        && (o_rsp.data[7:0] == $past(type_q));
  endproperty
  a_sel_flag: assert property (p_sel_flag) else $error("select read wrong");

  property p_rsv_zero;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_rsp.valid && (kind2_q != K_WIN) |-> (o_rsp.data[31:16] == 16'h0000);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");

  property p_edge_code;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_rsp.valid && (kind2_q == K_RNG) && ($past(type_q) != TYPE_REF)
        |-> (o_rsp.data[EDGE_VLD_LSB+:2] != 2'h3) && (o_rsp.data[12:0] == 13'h0000);
  endproperty
  a_edge_code: assert property (p_edge_code) else $error("bad edge code");

  property p_edge_pos;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_rsp.valid && (kind2_q == K_EDG) |-> (o_rsp.data[15:8] == $past(snp_info_q.pos0));
  endproperty
  a_edge_pos: assert property (p_edge_pos) else $error("edge zero wrong");

  property p_one_edge;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_rsp.valid && (kind2_q == K_EDG) && ($past(snp_info_q.edge_vld) != EDGE_BOTH)
        |-> (o_rsp.data[7:0] == 8'h00);
  endproperty
  a_one_edge: assert property (p_one_edge) else $error("edge one leaked");

  property p_win_ok;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      hit_win && !i_req.write |-> ##2 o_rsp.valid && !o_rsp.err;
  endproperty
  a_win_ok: assert property (p_win_ok) else $error("window read refused");

  property p_range;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_rsp.valid && (kind2_q == K_RNG) && ($past(type_q) == TYPE_REF)
        |-> (o_rsp.data[15:0] == {$past(snp_info_q.rng_end), $past(snp_info_q.rng_start)});
  endproperty
  a_range: assert property (p_range) else $error("range wrong");

  c_capture:  cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
                              capture && have_rdy_q);
  c_win_read: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
                              o_rsp.valid && (kind2_q == K_WIN));
  c_clear:    cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
                              flag_q ##1 !flag_q);
endmodule

/* File: dv/wvr_host_model.sv */
// Host controller model that polls the holding registers
`timescale 1ns/1ns
module wvr_host_model #(
  parameter int GAP_CYC = 2
) (
  input  wire logic              i_core_clk,
  input  wire wvr_pkg::wvr_rsp_t i_rsp,
  output wvr_pkg::wvr_req_t      o_req
);
  import wvr_pkg::*;
  logic [31:0] wave [WIN_WORDS];

  initial o_req = '0;

  // One transfer; the answer stands only between the first and second edge after the
  // taking edge, so it is picked up mid-cycle while it stands
  task automatic xfer(input logic w, input logic [19:0] a, input logic [15:0] d,
                      output wvr_rsp_t r);
    begin
      repeat (GAP_CYC) @(negedge i_core_clk);
      o_req = '{valid: 1'b1, write: w, addr: a, wdata: d};
      @(negedge i_core_clk);
      o_req = '0;
      @(negedge i_core_clk);
      r = i_rsp;
    end
  endtask

  // Type select carries the fixed reserved pattern in its upper byte
  task automatic wr_sel(input logic [7:0] t, output wvr_rsp_t r);
    begin
      xfer(1'b1, REG_TYPE_SEL, {8'h01, t}, r);
    end
  endtask

  // Whole waveform, first address to last, samples kept in index order
  task automatic rd_wave;
    wvr_rsp_t r;
    begin
      for (int i = 0; i < WIN_WORDS; i++) begin
        xfer(1'b0, REG_WIN_FIRST + 20'(i), 16'h0000, r);
        // A missing or refused answer is kept as unknown so it can never match
        wave[i] = (r.valid && !r.err) ? r.data : {32{1'bx}};
      end
    end
  endtask
endmodule

/* File: dv/wvr_top_bench.sv */
// Self-checking bench for the waveform readout register block
`timescale 1ns/1ns
module wvr_top_bench;
  import wvr_pkg::*;
  logic        i_core_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  wvr_req_t    req;
  wvr_rsp_t    rsp;
  wvr_smp_t    smp = '0;
  logic        done = 1'b0;
  wvr_info_t   info = '0;
  logic        mode_chg = 1'b0;
  logic        meas_rst = 1'b0;
  integer      seed = 32'hE110;
  int          num_errors = 0;
  int          n_tests = 0;
  logic [31:0] pend_mem [WIN_WORDS];
  logic [31:0] snap_mem [WIN_WORDS];
  wvr_info_t   pend_info;
  wvr_info_t   snap_info;
  logic        pend_ok = 1'b0;
  logic        flag = 1'b0;
  logic [7:0]  cur_t = TYPE_RST;
  wvr_rsp_t    wr;

  always #2 i_core_clk = ~i_core_clk;

  wvr_top dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(req), .o_rsp(rsp),
    .i_smp(smp), .i_frame_done(done), .i_frame_info(info), .i_mode_change(mode_chg),
    .i_meas_reset(meas_rst));
  wvr_host_model host (.i_core_clk(i_core_clk), .i_rsp(rsp), .o_req(req));

  task automatic summarize;
    begin
      $display("errors %0d of %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    begin
      n_tests++;
      if (g !== e) begin
        num_errors++;
        $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task automatic rd(input logic [19:0] a, input string nm, input logic [32:0] e);
    wvr_rsp_t r;
    begin
      host.xfer(1'b0, a, 16'h0000, r);
      // A missing answer shows as unknown and never matches
      chk(nm, e, r.valid ? {r.err, r.data} : {33{1'bx}});
    end
  endtask

  // Reference type shows the range, any other type the edge validity code
  function automatic logic [31:0] f_rng(input wvr_info_t f, input logic [7:0] t);
    return (t == TYPE_REF) ? {16'h0000, f.rng_end, f.rng_start} : {17'h0, f.edge_vld, 13'h0};
  endfunction

  // Edge one byte is undefined unless both edges are valid; design reads it as zero
  function automatic logic [31:0] f_pos(input wvr_info_t f);
    return {16'h0000, f.pos0, (f.edge_vld == EDGE_BOTH) ? f.pos1 : 8'h00};
  endfunction

  // Full frame plus one write at index 127, which must be dropped
  task automatic load_frame(input logic [1:0] ev);
    begin
      for (int i = 0; i <= WIN_WORDS; i++) begin
        @(negedge i_core_clk);
        smp.valid = 1'b1;
        smp.idx = i[6:0];
        smp.data = $random(seed);
        if (i < WIN_WORDS) pend_mem[i] = smp.data;
      end
      @(negedge i_core_clk);
      smp = '0;
      info = {ev, 32'($random(seed))};
      done = 1'b1;
      pend_info = info;
      pend_ok = 1'b1;
      @(negedge i_core_clk);
      done = 1'b0;
    end
  endtask

  // Select read captures a ready frame, if there is one
  task automatic rd_sel;
    begin
      if (pend_ok) begin
        snap_mem = pend_mem;
        snap_info = pend_info;
        flag = 1'b1;
        pend_ok = 1'b0;
      end
      rd(REG_TYPE_SEL, "select", {1'b0, 22'h0, flag, 1'b0, cur_t});
    end
  endtask

  initial begin
    repeat (2) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    rd_sel;
    for (int k = 0; k < 2; k++) begin
      cur_t = (k == 0) ? TYPE_REF : 8'h11;
      host.wr_sel(cur_t, wr);
      // A select write answers with the select word, showing the new type
      chk("sel write", {1'b0, 22'h0, flag, 1'b0, cur_t},
          wr.valid ? {wr.err, wr.data} : {33{1'bx}});
      for (int ev = 0; ev < 3; ev++) begin
        load_frame(ev[1:0]);
        rd_sel;
        host.rd_wave;
        for (int i = 0; i < WIN_WORDS; i++) begin
          chk("window", {1'b0, snap_mem[i]}, {1'b0, host.wave[i]});
        end
        rd(REG_RANGE, "range", {1'b0, f_rng(snap_info, cur_t)});
        rd(REG_EDGE_POS, "edge pos", {1'b0, f_pos(snap_info)});
      end
    end
    // A newer frame must not disturb the held snapshot until the next capture
    load_frame(EDGE_ONE);
    rd(REG_WIN_FIRST, "held word", {1'b0, snap_mem[0]});
    rd(REG_EDGE_POS, "held pos", {1'b0, f_pos(snap_info)});
    // Both clear sources drop the flag and the pending frame
    for (int k = 0; k < 2; k++) begin
      if (k == 1) load_frame(EDGE_BOTH);
      @(negedge i_core_clk);
      mode_chg = (k == 0);
      meas_rst = (k == 1);
      @(negedge i_core_clk);
      mode_chg = 1'b0;
      meas_rst = 1'b0;
      flag = 1'b0;
      pend_ok = 1'b0;
      rd_sel;
    end
    host.xfer(1'b1, REG_WIN_FIRST, 16'h1234, wr);
    chk("window write", {1'b1, 32'h0}, wr.valid ? {wr.err, wr.data} : {33{1'bx}});
    rd(20'h625CD, "unmapped", {1'b1, 32'h0});
    rd(20'h625CA, "past window", {1'b1, 32'h0});
    summarize;
  end

  // Hang guard, about six times the expected run of some 4200 cycles
  initial begin
    #100000;
    num_errors++;
    summarize;
  end
endmodule
